// >>> rtl/sbc_params.svh
// offsets, field positions, reset values and counts of the serial register block
// assumes inclusion by bare name from the design files
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH

`define SBC_FRAME_BITS 4'h8
`define SBC_CNT_SAT 4'hF

`define SBC_ADDR_MODE 4'h0
`define SBC_ADDR_VOLT_ALIAS 4'h1
`define SBC_ADDR_WAKE 4'h2
`define SBC_ADDR_WAKE_ALIAS 4'h3
`define SBC_ADDR_XCVR 4'h4
`define SBC_ADDR_XCVR_ALIAS 4'h5
`define SBC_ADDR_SWITCH 4'h6
`define SBC_ADDR_SWITCH_ALIAS 4'h7
`define SBC_ADDR_TIMING 4'hA
`define SBC_ADDR_TIMING_ALIAS 4'hB
`define SBC_ADDR_ASEL 4'hC
`define SBC_ADDR_CONFIG 4'hD
`define SBC_ADDR_IRQ 4'hE
`define SBC_ADDR_IRQ_ALIAS 4'hF

`define SBC_MODE_HIGH_VOLTAGE_SHUTDOWN_ENABLE_BIT 3
`define SBC_VOLT_OV_BIT 3
`define SBC_VOLT_UV_BIT 2
`define SBC_VOLT_OT_BIT 1
`define SBC_VOLT_BF_BIT 0
`define SBC_SUM_VOLT_BIT 3
`define SBC_SUM_XCVR_BIT 2
`define SBC_SUM_SWITCH_BIT 1
`define SBC_SUM_SPARE_BIT 0
`define SBC_XCVR_RXONLY_BIT 2

`define SBC_RST_MODE 4'h8
`define SBC_RST_WAKE 4'hF
`define SBC_RST_XCVR 4'h0
`define SBC_RST_SWITCH 4'h0
`define SBC_RST_TIMING 4'h0
`define SBC_RST_ASEL 4'h0
`define SBC_RST_CONFIG 4'h0
`define SBC_RST_IRQ 4'h0

`endif

// >>> rtl/sbc_pkg.sv
// types shared by the serial register block
// assumes sbc_params.svh for the numeric constants
package sbc_pkg;
    typedef logic [3:0] nibble_t;
    typedef logic [63:0] status_table_t;
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_STOP = 2'h1,
        MODE_SLEEP = 2'h2,
        MODE_NORMAL_WDCLR = 2'h3
    } mode_e;
endpackage

// >>> rtl/frame_if.sv
// carrier between the serial-clock side and the system-clock side
// assumes the frame words are stable whenever the other side reads them
`timescale 1ns/1ps
interface frame_if;
    logic [7:0] rx_byte;
    logic [3:0] rx_count;
    logic frame_tog;
    logic [3:0] summary;
    sbc_pkg::status_table_t table_w;

    modport link (output rx_byte, output rx_count, output frame_tog,
                  input summary, input table_w);
    modport core (input rx_byte, input rx_count, input frame_tog,
                  output summary, output table_w);
endinterface

// >>> rtl/spi_link.sv
// serial-clock side: shifts in address and control, shifts out status
// assumes the core keeps summary and table stable while chip select is low
`timescale 1ns/1ps
`include "sbc_params.svh"
module spi_link (
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso_o,
    output logic miso_oe,
    frame_if.link fr
);
    import sbc_pkg::*;

    logic first_q;
    logic [7:0] shift_q;
    logic [3:0] cnt_q;
    logic tog_q;
    logic [3:0] addr_q;
    logic [3:0] tx_cnt_q;
    logic [7:0] out_byte;

    function automatic nibble_t pick(input status_table_t t, input logic [3:0] a);
        pick = t[{a, 2'h0} +: 4];
    endfunction

    // marks the first sampling edge of a frame
    always_ff @(negedge sclk or posedge cs_n or posedge rst) begin
        if (rst || cs_n) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // sample on falling clock, address first then control
    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            shift_q <= 8'h00;
            cnt_q <= 4'h0;
            tog_q <= 1'b0;
            addr_q <= 4'h0;
        end else begin
            shift_q <= first_q ? {7'h00, mosi} : {shift_q[6:0], mosi};
            if (first_q) begin
                cnt_q <= 4'h1;
                tog_q <= ~tog_q;
            end else if (cnt_q != `SBC_CNT_SAT) begin
                cnt_q <= cnt_q + 4'h1;
            end
            if (!first_q && cnt_q == 4'h3) begin
                addr_q <= {shift_q[2:0], mosi};
            end
        end
    end

    // each rising clock moves the next reply bit out
    always_ff @(posedge sclk or posedge cs_n or posedge rst) begin
        if (rst || cs_n) begin
            tx_cnt_q <= 4'h0;
        end else if (tx_cnt_q != `SBC_FRAME_BITS) begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
        end
    end

    assign out_byte = {fr.summary, pick(fr.table_w, addr_q)};
    assign miso_o = (tx_cnt_q == 4'h0) ? out_byte[7] : out_byte[3'(4'h8 - tx_cnt_q)];
    assign miso_oe = ~cs_n;
    assign fr.rx_byte = shift_q;
    assign fr.rx_count = cnt_q;
    assign fr.frame_tog = tog_q;
endmodule

// >>> rtl/sbc_spi_register_interface.sv
// register map and frame commit of the system basis chip serial port
// assumes SCLK idles low and a frame gap of at least five CLK periods
//
// How it works
// - each frame returns four summary bits then the addressed status nibble
// - chip select falling starts frame, enables output, freezes returned status
// - outgoing bits change on rising serial clock, incoming sampled on falling
// - a frame counts only with exactly eight sampling edges under chip select
// - chip select rising ends frame and commits control nibble to addressed register
// - serial output floats while chip select is high
// - power-on resets all register bits; reset mode or reset pin resets only wake control, switch control and the receive-only bit
// - summary bits: voltage in 7, transceiver in 6, switch in 5, 4 reads zero
// - voltage summary is high when any voltage status bit is high
// - transceiver summary is high when any transceiver status bit is high
// - switch summary is high when any switch status bit is high
// - even address except 8, and address D, writes control and returns paired status; other odd ones only return it
// - a mode control write returns voltage status in the same frame
// - with shutdown enabled, supply over-voltage forces both switch drivers off
// - mode bits: 00 normal, 01 stop, 10 sleep, 11 normal plus watchdog clear
// - voltage nibble: over-voltage, under-voltage, regulator overtemp, battery fail
// - battery-fail flag is set by power-on reset
// - a frame of exactly eight edges to mode control or voltage status clears battery-fail after reporting
// - transceiver and switch control writes return their own status registers
`timescale 1ns/1ps
`include "sbc_params.svh"
module sbc_spi_register_interface (
    // system clock and power-on reset
    input wire logic CLK,
    input wire logic RST,
    // serial port pins
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic MOSI,
    output logic MISO_O,
    output logic MISO_OE,
    // reset mode or external reset pin
    input wire logic EXT_RESET_IN,
    // live monitor inputs
    input wire logic [2:0] VOLT_COND_IN,
    input wire logic [3:1] XCVR_STAT_IN,
    input wire logic [3:0] SWITCH_STAT_IN,
    input wire logic WAKE_PIN_IN,
    input wire logic [3:0] WDOG_STAT_IN,
    input wire logic [3:0] IRQ_CAUSE_IN,
    // control outputs
    output sbc_pkg::mode_e MODE,
    output logic WDOG_CLEAR,
    output logic HIGH_VOLTAGE_SHUTDOWN_ENABLE,
    output logic [1:0] SWITCH_ON,
    output logic [1:0] SWITCH_PWM_EN,
    output logic [3:0] WAKE_CTRL,
    output logic [3:0] XCVR_CTRL,
    output logic [3:0] TIMING_CTRL,
    output logic [3:0] ASEL_CTRL,
    output logic [3:0] CONFIG_CTRL,
    output logic [3:0] IRQ_MASK
);
    import sbc_pkg::*;

    localparam int MON_W = 20;

    frame_if fr ();

    logic [2:0] cs_sync_q;
    logic [1:0] tog_sync_q;
    logic [MON_W-1:0] mon_s1_q;
    logic [MON_W-1:0] mon_q;
    logic [1:0] ext_sync_q;
    logic frame_end;
    logic frame_ok;
    logic [3:0] addr;
    logic [3:0] ctrl;
    logic wr_en;
    logic tog_done_q;

    logic [3:0] mode_ctrl_q;
    logic battery_fail_flag_q;
    logic [3:0] wake_ctrl_q;
    logic [3:0] xcvr_ctrl_q;
    logic [3:0] switch_ctrl_q;
    logic [3:0] timing_ctrl_q;
    logic [3:0] asel_ctrl_q;
    logic [3:0] config_ctrl_q;
    logic [3:0] irq_mask_q;
    logic wdog_clear_q;

    nibble_t voltage_status_register;
    nibble_t wake_status;
    nibble_t bus_transceiver_status_register;
    nibble_t switch_driver_status_register;
    logic [3:0] system_summary_register;
    status_table_t table_d;
    status_table_t table_q;
    logic [3:0] summary_q;
    logic supply_over_voltage;
    logic shutdown_now;
    logic ext_reset;

    function automatic nibble_t status_of(input logic [3:0] a, input nibble_t v, input nibble_t w,
                                          input nibble_t x, input nibble_t s, input nibble_t d,
                                          input nibble_t q);
        case (a[3:1])
            3'h0: status_of = v;
            3'h1: status_of = w;
            3'h2: status_of = x;
            3'h3: status_of = s;
            3'h5: status_of = d;
            3'h7: status_of = q;
            default: status_of = 4'h0;
        endcase
    endfunction

    function automatic logic is_write_addr(input logic [3:0] a);
        is_write_addr = (a[0] == 1'b0 && a != 4'h8) || a == `SBC_ADDR_CONFIG;
    endfunction

    spi_link u_link (
        .rst(RST),
        .sclk(SCLK),
        .cs_n(CS_N),
        .mosi(MOSI),
        .miso_o(MISO_O),
        .miso_oe(MISO_OE),
        .fr(fr.link)
    );

    // chip select and frame toggle brought onto CLK
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cs_sync_q <= 3'h7;
            tog_sync_q <= 2'h0;
        end else begin
            cs_sync_q <= {cs_sync_q[1:0], CS_N};
            tog_sync_q <= {tog_sync_q[0], fr.frame_tog};
        end
    end

    // monitor pins and reset request pass two flops
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mon_s1_q <= '0;
            mon_q <= '0;
            ext_sync_q <= 2'h0;
        end else begin
            mon_s1_q <= {VOLT_COND_IN, XCVR_STAT_IN, SWITCH_STAT_IN, WAKE_PIN_IN,
                         WDOG_STAT_IN, IRQ_CAUSE_IN, 1'b0};
            mon_q <= mon_s1_q;
            ext_sync_q <= {ext_sync_q[0], EXT_RESET_IN};
        end
    end

    assign ext_reset = ext_sync_q[1];
    assign supply_over_voltage = mon_q[19];

    // frame end seen once chip select has risen; words are quiet by then
    assign frame_end = cs_sync_q[1] & ~cs_sync_q[2];
    // a frame without sampling edges leaves the count of the last frame behind
    assign frame_ok = frame_end && tog_sync_q[1] != tog_done_q
                      && fr.rx_count == `SBC_FRAME_BITS;

    // toggle value of the last frame already judged
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tog_done_q <= 1'b0;
        end else if (frame_end) begin
            tog_done_q <= tog_sync_q[1];
        end
    end
    assign addr = fr.rx_byte[7:4];
    assign ctrl = fr.rx_byte[3:0];
    assign wr_en = frame_ok && is_write_addr(addr);

    // live status nibbles
    assign voltage_status_register = {mon_q[19:17], battery_fail_flag_q};
    assign wake_status = {3'h0, mon_q[9] & wake_ctrl_q[0]};
    assign bus_transceiver_status_register = {mon_q[16:14], 1'b0};
    assign switch_driver_status_register = mon_q[13:10];
    assign system_summary_register = {|voltage_status_register,
                                      |bus_transceiver_status_register,
                                      |switch_driver_status_register,
                                      1'b0};

    always_comb begin
        table_d = '0;
        for (int i = 0; i < 16; i++) begin
            table_d[i*4 +: 4] = status_of(4'(i), voltage_status_register, wake_status,
                                          bus_transceiver_status_register,
                                          switch_driver_status_register,
                                          mon_q[8:5], mon_q[4:1]);
        end
    end

    // returned status follows live values only while chip select is high
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            table_q <= '0;
            summary_q <= 4'h0;
        end else if (cs_sync_q[1]) begin
            table_q <= table_d;
            summary_q <= system_summary_register;
        end
    end

    assign fr.table_w = table_q;
    assign fr.summary = summary_q;

    // mode control: shutdown enable resets on power-on only
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mode_ctrl_q <= `SBC_RST_MODE;
        end else if (wr_en && addr == `SBC_ADDR_MODE) begin
            mode_ctrl_q <= {ctrl[3], 1'b0, ctrl[1:0]};
        end
    end

    // watchdog clear pulses on a valid 11 mode write
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wdog_clear_q <= 1'b0;
        end else begin
            wdog_clear_q <= wr_en && addr == `SBC_ADDR_MODE
                            && ctrl[1:0] == MODE_NORMAL_WDCLR;
        end
    end

    // battery fail: set by power-on, cleared after a frame to address 0 or 1
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            battery_fail_flag_q <= 1'b1;
        end else if (frame_ok && addr[3:1] == 3'h0) begin
            battery_fail_flag_q <= 1'b0;
        end
    end

    // wake control: all reset sources
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wake_ctrl_q <= `SBC_RST_WAKE;
        end else if (ext_reset) begin
            wake_ctrl_q <= `SBC_RST_WAKE;
        end else if (wr_en && addr == `SBC_ADDR_WAKE) begin
            wake_ctrl_q <= {3'h0, ctrl[0]};
        end
    end

    // transceiver control: receive-only bit also follows the reset pin
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            xcvr_ctrl_q <= `SBC_RST_XCVR;
        end else if (wr_en && addr == `SBC_ADDR_XCVR) begin
            xcvr_ctrl_q <= ctrl;
        end else if (ext_reset) begin
            xcvr_ctrl_q[`SBC_XCVR_RXONLY_BIT] <= 1'b0;
        end
    end

    // switch control: over-voltage shutdown drops both switch bits
    assign shutdown_now = supply_over_voltage && mode_ctrl_q[`SBC_MODE_HIGH_VOLTAGE_SHUTDOWN_ENABLE_BIT];
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            switch_ctrl_q <= `SBC_RST_SWITCH;
        end else if (ext_reset) begin
            switch_ctrl_q <= `SBC_RST_SWITCH;
        end else if (shutdown_now) begin
            switch_ctrl_q[1:0] <= 2'h0;
            if (wr_en && addr == `SBC_ADDR_SWITCH) begin
                switch_ctrl_q[3:2] <= ctrl[3:2];
            end
        end else if (wr_en && addr == `SBC_ADDR_SWITCH) begin
            switch_ctrl_q <= ctrl;
        end
    end

    // remaining control registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            timing_ctrl_q <= `SBC_RST_TIMING;
            asel_ctrl_q <= `SBC_RST_ASEL;
            config_ctrl_q <= `SBC_RST_CONFIG;
            irq_mask_q <= `SBC_RST_IRQ;
        end else if (wr_en) begin
            case (addr)
                `SBC_ADDR_TIMING: timing_ctrl_q <= ctrl;
                `SBC_ADDR_ASEL: asel_ctrl_q <= ctrl;
                `SBC_ADDR_CONFIG: config_ctrl_q <= {ctrl[3:2], 2'h0};
                `SBC_ADDR_IRQ: irq_mask_q <= {ctrl[3], 1'b0, ctrl[1:0]};
                default: ;
            endcase
        end
    end

    assign MODE = mode_e'(mode_ctrl_q[1:0]);
    assign WDOG_CLEAR = wdog_clear_q;
    assign HIGH_VOLTAGE_SHUTDOWN_ENABLE = mode_ctrl_q[`SBC_MODE_HIGH_VOLTAGE_SHUTDOWN_ENABLE_BIT];
    assign SWITCH_ON = switch_ctrl_q[1:0];
    assign SWITCH_PWM_EN = switch_ctrl_q[3:2];
    assign WAKE_CTRL = wake_ctrl_q;
    assign XCVR_CTRL = xcvr_ctrl_q;
    assign TIMING_CTRL = timing_ctrl_q;
    assign ASEL_CTRL = asel_ctrl_q;
    assign CONFIG_CTRL = config_ctrl_q;
    assign IRQ_MASK = irq_mask_q;
endmodule

// >>> verification/spi_master_model.sv
// serial master model: one chip-select period per call
// assumes the bench resolves the data-out wire from the enable
`timescale 1ns/1ps
module spi_master_model (
    // serial pins
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // link clock runs only inside frames, 80 ns period
    task automatic xfer(input logic [7:0] tx, input int edges, output logic [7:0] rx);
        rx = 8'h00;
        #7;
        cs_n = 1'b0;
        #250;
        for (int i = 0; i < edges; i++) begin
            sclk = 1'b1;
            mosi = tx[7 - (i % 8)];
            #40;
            rx = {rx[6:0], miso};
            sclk = 1'b0;
            #40;
        end
        cs_n = 1'b1;
        // released line must not look like the last bit
        mosi = ~mosi;
        #500;
    endtask
endmodule

// >>> verification/sbc_checker.sv
// concurrent checks on the serial register block ports
// assumes binding to the top module below
`timescale 1ns/1ps
module sbc_checker (
    // clocks and reset
    input wire logic CLK,
    input wire logic RST,
    input wire logic SCLK,
    input wire logic CS_N,
    // observed
    input wire logic MISO_O,
    input wire logic MISO_OE,
    input wire logic EXT_RESET_IN,
    input wire logic [2:0] VOLT_COND_IN,
    input sbc_pkg::mode_e MODE,
    input wire logic WDOG_CLEAR,
    input wire logic HIGH_VOLTAGE_SHUTDOWN_ENABLE,
    input wire logic [1:0] SWITCH_ON,
    input wire logic [3:0] WAKE_CTRL,
    input wire logic [3:0] XCVR_CTRL,
    input wire logic [3:0] IRQ_MASK
);
    import sbc_pkg::*;
    logic [3:0] rise_q;
    // rising serial edges seen in this frame
    always_ff @(posedge SCLK or posedge CS_N) begin
        if (CS_N) begin
            rise_q <= 4'h0;
        end else begin
            rise_q <= rise_q + 4'h1;
        end
    end
    oe_follows_a: assert property (@(posedge CLK) disable iff (RST)
        MISO_OE == !CS_N) else $error("enable differs from select");
    spare_zero_a: assert property (@(negedge SCLK) disable iff (RST)
        !CS_N && rise_q == 4'h4 |-> !MISO_O) else $error("spare bit not zero");
    wdclr_pulse_a: assert property (@(posedge CLK) disable iff (RST)
        WDOG_CLEAR |=> !WDOG_CLEAR) else $error("clear pulse too long");
    wdclr_mode_a: assert property (@(posedge CLK) disable iff (RST)
        WDOG_CLEAR |-> MODE == MODE_NORMAL_WDCLR) else $error("clear without mode 3");
    hv_cut_a: assert property (@(posedge CLK) disable iff (RST)
        (HIGH_VOLTAGE_SHUTDOWN_ENABLE && VOLT_COND_IN[2]) [*6] |-> SWITCH_ON == 2'h0)
        else $error("switches on in over-voltage");
    ext_reset_a: assert property (@(posedge CLK) disable iff (RST)
        EXT_RESET_IN [*5] |-> WAKE_CTRL == 4'hF && SWITCH_ON == 2'h0 && !XCVR_CTRL[2])
        else $error("reset pin ignored");
    frame_hold_a: assert property (@(posedge CLK) disable iff (RST)
        !CS_N [*4] |=> $stable(IRQ_MASK) && $stable(XCVR_CTRL))
        else $error("write inside frame");
    commit_late_a: assert property (@(posedge CLK) disable iff (RST)
        $changed(IRQ_MASK) |-> CS_N && $past(CS_N, 2)) else $error("early commit");
    cover property (@(posedge CLK) WDOG_CLEAR);
    cover property (@(posedge CLK) $rose(CS_N));
    cover property (@(posedge CLK) $changed(IRQ_MASK));
endmodule
bind sbc_spi_register_interface sbc_checker u_chk (.CLK(CLK), .RST(RST), .SCLK(SCLK),
    .CS_N(CS_N), .MISO_O(MISO_O), .MISO_OE(MISO_OE), .EXT_RESET_IN(EXT_RESET_IN),
    .VOLT_COND_IN(VOLT_COND_IN), .MODE(MODE), .WDOG_CLEAR(WDOG_CLEAR),
    .HIGH_VOLTAGE_SHUTDOWN_ENABLE(HIGH_VOLTAGE_SHUTDOWN_ENABLE), .SWITCH_ON(SWITCH_ON),
    .WAKE_CTRL(WAKE_CTRL), .XCVR_CTRL(XCVR_CTRL), .IRQ_MASK(IRQ_MASK));

// >>> verification/sbc_spi_register_interface_tb.sv
// self-checking bench of the serial register block
// assumes the master model drives the serial pins
`timescale 1ns/1ps
module sbc_spi_register_interface_tb;
    import sbc_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic EXT_RESET_IN = 1'b0;
    logic [2:0] VOLT_COND_IN = 3'h0;
    logic [3:1] XCVR_STAT_IN = 3'h0;
    logic [3:0] SWITCH_STAT_IN = 4'h0;
    logic WAKE_PIN_IN = 1'b0;
    logic [3:0] WDOG_STAT_IN = 4'h0;
    logic [3:0] IRQ_CAUSE_IN = 4'h0;
    logic SCLK, CS_N, MOSI, MISO_O, MISO_OE, WDOG_CLEAR, HIGH_VOLTAGE_SHUTDOWN_ENABLE;
    mode_e MODE;
    logic [1:0] SWITCH_ON, SWITCH_PWM_EN;
    logic [3:0] WAKE_CTRL, XCVR_CTRL, TIMING_CTRL, ASEL_CTRL, CONFIG_CTRL, IRQ_MASK;
    logic [7:0] r;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    wire miso_w = MISO_OE ? MISO_O : 1'bz;
    always #25 CLK = ~CLK;
    sbc_spi_register_interface uut (.CLK(CLK), .RST(RST), .SCLK(SCLK), .CS_N(CS_N),
        .MOSI(MOSI), .MISO_O(MISO_O), .MISO_OE(MISO_OE), .EXT_RESET_IN(EXT_RESET_IN),
        .VOLT_COND_IN(VOLT_COND_IN), .XCVR_STAT_IN(XCVR_STAT_IN),
        .SWITCH_STAT_IN(SWITCH_STAT_IN), .WAKE_PIN_IN(WAKE_PIN_IN),
        .WDOG_STAT_IN(WDOG_STAT_IN), .IRQ_CAUSE_IN(IRQ_CAUSE_IN), .MODE(MODE),
        .WDOG_CLEAR(WDOG_CLEAR), .HIGH_VOLTAGE_SHUTDOWN_ENABLE(HIGH_VOLTAGE_SHUTDOWN_ENABLE),
        .SWITCH_ON(SWITCH_ON), .SWITCH_PWM_EN(SWITCH_PWM_EN), .WAKE_CTRL(WAKE_CTRL),
        .XCVR_CTRL(XCVR_CTRL), .TIMING_CTRL(TIMING_CTRL), .ASEL_CTRL(ASEL_CTRL),
        .CONFIG_CTRL(CONFIG_CTRL), .IRQ_MASK(IRQ_MASK));
    spi_master_model u_mst (.sclk(SCLK), .cs_n(CS_N), .mosi(MOSI), .miso(miso_w));
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // settle synced inputs, run one frame, let the commit land
    task automatic frame(input logic [3:0] a, input logic [3:0] c, input int n);
        repeat (4) @(posedge CLK);
        u_mst.xfer({a, c}, n, r);
        repeat (4) @(posedge CLK);
    endtask
    task automatic t_reset();
        chk("rst_a", {MODE, HIGH_VOLTAGE_SHUTDOWN_ENABLE, SWITCH_PWM_EN, SWITCH_ON, WAKE_CTRL},
            16'h010F);
        chk("rst_b", {XCVR_CTRL, TIMING_CTRL, ASEL_CTRL, CONFIG_CTRL}, 16'h0000);
        chk("rst_c", IRQ_MASK, 16'h0000);
        frame(4'h0, 4'h3, 7);
        frame(4'h1, 4'h3, 9);
        chk("short", {MODE, HIGH_VOLTAGE_SHUTDOWN_ENABLE}, 16'h0001);
        frame(4'h1, 4'h0, 8);
        chk("batt_set", r, 16'h0081);
        frame(4'h1, 4'h0, 8);
        chk("batt_clr", r, 16'h0000);
    endtask
    task automatic t_mode();
        @(posedge CLK) VOLT_COND_IN <= 3'h3;
        for (int m = 0; m < 4; m++) begin
            frame(4'h0, 4'(m), 8);
            chk("mode_ret", r, 16'h0086);
            chk("mode", {MODE, HIGH_VOLTAGE_SHUTDOWN_ENABLE}, 16'(m * 2));
        end
        @(posedge CLK) VOLT_COND_IN <= 3'h0;
        frame(4'h0, 4'h8, 8);
    endtask
    task automatic t_switch();
        @(posedge CLK) SWITCH_STAT_IN <= 4'h5;
        frame(4'h6, 4'hF, 8);
        chk("sw_ret", r, 16'h0025);
        chk("sw_ctl", {SWITCH_PWM_EN, SWITCH_ON}, 16'h000F);
        frame(4'h7, 4'h0, 8);
        chk("sw_alias", {r, SWITCH_PWM_EN, SWITCH_ON}, 16'h025F);
        @(posedge CLK) VOLT_COND_IN <= 3'h4;
        repeat (8) @(posedge CLK);
        chk("hv_cut", {SWITCH_PWM_EN, SWITCH_ON}, 16'h000C);
        @(posedge CLK) VOLT_COND_IN <= 3'h0;
        frame(4'h0, 4'h0, 8);
        frame(4'h6, 4'h3, 8);
        @(posedge CLK) VOLT_COND_IN <= 3'h4;
        repeat (8) @(posedge CLK);
        chk("hv_off", SWITCH_ON, 16'h0003);
        @(posedge CLK) VOLT_COND_IN <= 3'h0;
        SWITCH_STAT_IN <= 4'h0;
        frame(4'h0, 4'h8, 8);
    endtask
    task automatic t_xcvr();
        @(posedge CLK) XCVR_STAT_IN <= 3'h2;
        frame(4'h5, 4'hF, 8);
        chk("xc_alias", {r, XCVR_CTRL}, 16'h0440);
        frame(4'h4, 4'hF, 8);
        chk("xc_write", {r, XCVR_CTRL}, 16'h044F);
        @(posedge CLK) XCVR_STAT_IN <= 3'h0;
    endtask
    task automatic t_misc();
        logic [11:0] tbl [5] = '{12'hA59, 12'hCA0, 12'hDF0, 12'hEC6, 12'h870};
        @(posedge CLK) WDOG_STAT_IN <= 4'h9;
        IRQ_CAUSE_IN <= 4'h6;
        WAKE_PIN_IN <= 1'b1;
        foreach (tbl[i]) begin
            frame(tbl[i][11:8], tbl[i][7:4], 8);
            chk("map_ret", r, {12'h000, tbl[i][3:0]});
        end
        chk("map_ctl", {TIMING_CTRL, ASEL_CTRL, CONFIG_CTRL, IRQ_MASK}, 16'h5AC8);
        frame(4'h2, 4'h0, 8);
        chk("wake_on", r, 16'h0001);
        frame(4'h3, 4'h0, 8);
        chk("wake_off", {r, WAKE_CTRL}, 16'h0000);
    endtask
    task automatic t_ext();
        frame(4'h6, 4'h3, 8);
        @(posedge CLK) EXT_RESET_IN <= 1'b1;
        repeat (6) @(posedge CLK);
        EXT_RESET_IN <= 1'b0;
        repeat (6) @(posedge CLK);
        chk("ext_rst", {WAKE_CTRL, SWITCH_ON, XCVR_CTRL, TIMING_CTRL}, 16'h3CB5);
        // select without clock must not replay the last valid write
        frame(4'h6, 4'h3, 0);
        chk("no_edges", SWITCH_ON, 16'h0000);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        repeat (4) @(posedge CLK);
        t_reset();
        t_mode();
        t_switch();
        t_xcvr();
        t_misc();
        t_ext();
        summarize();
    end
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            summarize();
        end
    end
endmodule
